// file: hw/fab_pkg.sv
// constants, variant table and decode functions of the fuse array
// Contract
// (RQ1) small array: 10 to 16 input pairs, 16 product terms, at most 512 fuses
// (RQ2) small family has nine variants differing in outputs and terms per output
// (RQ3) all terms of one output are ORed into its sum-of-products value; medium combinatorial outputs OR seven, their first term drives the enable
// (RQ4) intact fuse connects an input phase to a term; blown fuse disconnects it
// (RQ5) a term is true only while every connected input line is high
// (RQ6) both phases of one input connected keeps the term false
// (RQ7) a term with every fuse blown stays true, driving its function high
// (RQ8) toggling an input tied to no term leaves all outputs unchanged
// (RQ9) after the security fuse is blown, programming and verify are refused
// (RQ10) programmer blows the security fuse only after all others are verified
// (RQ11) fuse number is product line first fuse plus input line number
// (RQ12) medium array: 16 input pairs, 8 outputs, one AND array, fixed OR
// (RQ13) each medium output is combinatorial or passes through a D flip-flop
// (RQ14) outputs can float so pins may serve as inputs and outputs
// (RQ15) fast series clears all output registers at power-up
// (RQ16) fast series accepts direct register preload of any state
// (RQ17) registers share one clock, capture on rising edge, feed back to array
// (RQ18) each combinatorial output has a fixed polarity per variant after the OR
package fab_pkg;

  localparam int NUM_IN    = 16;
  localparam int NUM_COL   = 32;
  localparam int NUM_PT    = 64;
  localparam int NUM_OUT   = 8;
  localparam int PT_PER_OUT = 8;
  localparam int SMALL_PT  = 16;
  localparam int NUM_DED   = 10;
  localparam int NUM_FUSE  = 2048;
  localparam int FIDX_W    = 11;
  localparam int SMALL_FUSE = 512;
  localparam int MED_DED   = 8;

  localparam logic       FUSE_INTACT = 1'b0;
  localparam logic       FUSE_BLOWN  = 1'b1;
  localparam logic [7:0] REG_RESET   = 8'h00;

  typedef enum {
    FAB_SM_10_HI, FAB_SM_12_HI, FAB_SM_14_HI, FAB_SM_16_HI,
    FAB_SM_10_LO, FAB_SM_12_LO, FAB_SM_14_LO, FAB_SM_16_LO,
    FAB_SM_16_CP, FAB_MD_COMB, FAB_MD_REG4, FAB_MD_REG6, FAB_MD_REG8
  } fab_variant_t;

  // small variants use the 16-term array
  function automatic logic is_small(fab_variant_t v);
    return v <= FAB_SM_16_CP;
  endfunction

  // number of array input pairs wired up
  function automatic int var_inputs(fab_variant_t v);
    unique case (v)
      FAB_SM_10_HI, FAB_SM_10_LO: return 10;
      FAB_SM_12_HI, FAB_SM_12_LO: return 12;
      FAB_SM_14_HI, FAB_SM_14_LO: return 14;
      default:                    return NUM_IN;
    endcase
  endfunction

  // number of logic functions (complementary pair counts once)
  function automatic int var_funcs(fab_variant_t v);
    unique case (v)
      FAB_SM_10_HI, FAB_SM_10_LO: return 8;
      FAB_SM_12_HI, FAB_SM_12_LO: return 6;
      FAB_SM_14_HI, FAB_SM_14_LO: return 4;
      FAB_SM_16_HI, FAB_SM_16_LO: return 2;
      FAB_SM_16_CP:               return 1;
      default:                    return NUM_OUT;
    endcase
  endfunction

  // pins driven as outputs
  function automatic int var_pins(fab_variant_t v);
    return (v == FAB_SM_16_CP) ? 2 : var_funcs(v);
  endfunction

  // registered macrocells of the medium array
  function automatic logic [7:0] reg_mask(fab_variant_t v);
    unique case (v)
      FAB_MD_REG4: return 8'h3C;
      FAB_MD_REG6: return 8'h7E;
      FAB_MD_REG8: return 8'hFF;
      default:     return 8'h00;
    endcase
  endfunction

  // active low output pins
  function automatic logic [7:0] low_mask(fab_variant_t v);
    unique case (v)
      FAB_SM_10_HI, FAB_SM_12_HI, FAB_SM_14_HI, FAB_SM_16_HI: return 8'h00;
      FAB_SM_16_CP: return 8'h02;
      default:      return 8'hFF;
    endcase
  endfunction

  // terms ORed into function k
  function automatic logic [NUM_PT-1:0] or_mask(fab_variant_t v, int k);
    logic [NUM_PT-1:0] m;
    int n;
    m = '0;
    n = var_funcs(v);
    if (is_small(v)) begin
      for (int t = 0; t < SMALL_PT; t++) begin
        if (k < n && t >= k * SMALL_PT / n && t < (k + 1) * SMALL_PT / n) begin
          m[t] = 1'b1;
        end
      end
    end else begin
      for (int t = 0; t < PT_PER_OUT; t++) begin
        m[k * PT_PER_OUT + t] = 1'b1;
      end
      if (!reg_mask(v)[k]) begin
        m[k * PT_PER_OUT] = 1'b0;
      end
    end
    return m;
  endfunction

endpackage

// file: hw/fab_arr_if.sv
// carrier between fuse store and the product-term plane
`timescale 1ns/100ps
interface fab_arr_if;
  import fab_pkg::*;
  logic [NUM_COL-1:0]  lines;
  logic [NUM_COL-1:0]  col_en;
  logic [NUM_FUSE-1:0] fuse;
  logic [NUM_PT-1:0]   terms;
  modport plane (input lines, col_en, fuse, output terms);
  modport ctrl  (output lines, col_en, fuse, input terms);
endinterface

// file: hw/fab_and_plane.sv
// programmable AND plane: one product term per fuse row
`timescale 1ns/100ps
module fab_and_plane (
  fab_arr_if.plane arr
);
  import fab_pkg::*;

  // blown fuse or absent column counts as high
  for (genvar t = 0; t < NUM_PT; t++) begin : g_term
    wire [NUM_COL-1:0] row = arr.fuse[t*NUM_COL +: NUM_COL];     // [RQ11]
    assign arr.terms[t] = &(arr.lines | row | ~arr.col_en);      // [RQ4] [RQ5] [RQ6] [RQ7]
  end

endmodule

// file: hw/fab_macrocell.sv
// one output cell: optional D flip-flop, polarity and three-state driver
`timescale 1ns/100ps
module fab_macrocell (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic sum_i,
  input  wire logic oe_term_i,
  input  wire logic use_term_oe_i,
  input  wire logic registered_i,
  input  wire logic active_low_i,
  input  wire logic present_i,
  input  wire logic out_en_n_i,
  input  wire logic preload_i,
  input  wire logic preload_val_i,
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe_o,
  output logic      fb_o
);
  import fab_pkg::*;

  logic q_q;
  logic q_d;
  logic level;

  // preload overrides the captured sum
  assign q_d = preload_i ? preload_val_i : sum_i;                 // [RQ16]

  // shared clock, cleared at power-up
  always_ff @(posedge clock_i or negedge rst_n_i) begin           // [RQ15] [RQ17]
    if (!rst_n_i) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  // path select and fixed polarity after the OR
  assign level    = registered_i ? q_q : sum_i;                   // [RQ13]
  assign pin_o    = level ^ active_low_i;                         // [RQ18]
  assign pin_oe_o = present_i &
                    (registered_i ? ~out_en_n_i : (~use_term_oe_i | oe_term_i)); // [RQ14]
  // registers feed back their state, others read the pin
  assign fb_o     = registered_i ? (q_q ^ active_low_i) : pin_i;  // [RQ17] [RQ14]

endmodule

// file: hw/fab_array_top.sv
// fuse-programmed AND-OR array with fuse store, security and output cells
`timescale 1ns/100ps
module fab_array_top #(
  parameter fab_pkg::fab_variant_t VARIANT     = fab_pkg::FAB_MD_REG4,
  parameter bit                    FAST_SERIES = 1'b1
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire logic [fab_pkg::NUM_DED-1:0]  in_i,
  input  wire logic [fab_pkg::NUM_OUT-1:0]  io_i,
  output logic      [fab_pkg::NUM_OUT-1:0]  io_o,
  output logic      [fab_pkg::NUM_OUT-1:0]  io_oe_o,
  input  wire logic                         out_en_n_i,
  input  wire logic                         preload_en_i,
  input  wire logic [fab_pkg::NUM_OUT-1:0]  preload_data_i,
  input  wire logic                         prog_blow_i,
  input  wire logic [fab_pkg::FIDX_W-1:0]   prog_addr_i,
  input  wire logic                         verify_req_i,
  output logic                              verify_valid_o,
  output logic                              verify_data_o,
  input  wire logic                         secure_blow_i,
  output logic                              secured_o,
  output logic                              refused_o
);
  import fab_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // variant constants

  localparam int          N_IN    = var_inputs(VARIANT);
  localparam int          N_FUNC  = var_funcs(VARIANT);
  localparam int          N_PINS  = var_pins(VARIANT);
  localparam logic        SMALL   = is_small(VARIANT);
  localparam logic [7:0]  REGS    = reg_mask(VARIANT);
  localparam logic [7:0]  LOWS    = low_mask(VARIANT);
  localparam int          FUSE_LIM = SMALL ? SMALL_FUSE : NUM_FUSE;

  // pin that feeds small-array input j above the dedicated ones
  function automatic int small_io_idx(int j);
    return (N_PINS + j - NUM_DED) % NUM_OUT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fuse store and security fuse

  logic [NUM_FUSE-1:0] fuse_q;
  logic                secure_q;
  logic                verify_valid_q;
  logic                verify_data_q;
  logic                refused_q;

  wire addr_ok    = 32'(prog_addr_i) < FUSE_LIM;
  wire prog_try   = prog_blow_i | verify_req_i;
  wire locked     = secure_q;
  wire blow_go    = prog_blow_i & addr_ok & ~locked;              // [RQ9]
  wire verify_go  = verify_req_i & ~prog_blow_i & ~locked;        // [RQ9]
  wire addr_fuse  = addr_ok ? fuse_q[prog_addr_i] : FUSE_INTACT;

  // blowing a fuse only ever sets it; address is row first fuse plus line
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fuse_q <= {NUM_FUSE{FUSE_INTACT}};
    end else if (blow_go) begin
      fuse_q[prog_addr_i] <= FUSE_BLOWN;                          // [RQ11] [RQ4]
    end
  end

  // security fuse, one-way; the programmer blows it last
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      secure_q <= 1'b0;
    end else if (secure_blow_i) begin
      secure_q <= 1'b1;                                           // [RQ9] [RQ10]
    end
  end

  // verify read-back, one cycle after the request
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      verify_valid_q <= 1'b0;
      verify_data_q  <= 1'b0;
    end else begin
      verify_valid_q <= verify_go;
      verify_data_q  <= verify_go ? addr_fuse : 1'b0;             // [RQ9]
    end
  end

  // refusal pulse once locked
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= prog_try & locked;                             // [RQ9]
    end
  end

  assign verify_valid_o = verify_valid_q;
  assign verify_data_o  = verify_data_q;
  assign secured_o      = secure_q;
  assign refused_o      = refused_q;

  ////////////////////////////////////////////////////////////////////////////
  // array inputs: dedicated pins, pins as inputs, and feedback

  logic [NUM_IN-1:0]  arr_in;
  logic [NUM_OUT-1:0] fb;

  for (genvar j = 0; j < NUM_IN; j++) begin : g_in
    if (SMALL) begin : g_small
      if (j < NUM_DED) begin : g_ded
        assign arr_in[j] = in_i[j];
      end else begin : g_pin
        assign arr_in[j] = io_i[small_io_idx(j)];
      end
    end else begin : g_med
      if (j < MED_DED) begin : g_ded
        assign arr_in[j] = in_i[j];
      end else if (VARIANT == FAB_MD_COMB && j == MED_DED) begin : g_ex0
        assign arr_in[j] = in_i[MED_DED];
      end else if (VARIANT == FAB_MD_COMB && j == NUM_IN - 1) begin : g_ex1
        assign arr_in[j] = in_i[MED_DED + 1];
      end else begin : g_fb
        assign arr_in[j] = fb[j - MED_DED];                       // [RQ17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AND plane: true and complement lines, unwired columns masked

  fab_arr_if arr ();

  for (genvar j = 0; j < NUM_IN; j++) begin : g_col
    assign arr.lines[2*j]      = arr_in[j];                       // [RQ4]
    assign arr.lines[2*j+1]    = ~arr_in[j];                      // [RQ4]
    assign arr.col_en[2*j]     = (j < N_IN);                      // [RQ1] [RQ12]
    assign arr.col_en[2*j+1]   = (j < N_IN);                      // [RQ8]
  end
  assign arr.fuse = fuse_q;

  fab_and_plane u_plane (
    .arr (arr.plane)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fixed OR plane

  logic [NUM_OUT-1:0] sum;
  logic [NUM_OUT-1:0] oe_term;

  for (genvar k = 0; k < NUM_OUT; k++) begin : g_or
    localparam logic [NUM_PT-1:0] OM = or_mask(VARIANT, k);
    assign sum[k]     = |(arr.terms & OM);                        // [RQ3] [RQ2] [RQ12]
    assign oe_term[k] = SMALL ? 1'b1 : arr.terms[k*PT_PER_OUT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // output cells; complementary variant mirrors function 0 on pin 1

  for (genvar k = 0; k < NUM_OUT; k++) begin : g_cell
    localparam int SRC = (VARIANT == FAB_SM_16_CP) ? 0 : k;
    fab_macrocell u_cell (
      .clock_i       (clock_i),
      .rst_n_i       (rst_n_i),
      .sum_i         (sum[SRC]),
      .oe_term_i     (oe_term[SRC]),
      .use_term_oe_i (~SMALL),
      .registered_i  (REGS[k]),                                   // [RQ13]
      .active_low_i  (LOWS[k]),                                   // [RQ18]
      .present_i     (k < N_PINS),
      .out_en_n_i    (out_en_n_i),
      .preload_i     (FAST_SERIES & preload_en_i),                // [RQ16]
      .preload_val_i (preload_data_i[k]),
      .pin_i         (io_i[k]),
      .pin_o         (io_o[k]),
      .pin_oe_o      (io_oe_o[k]),                                // [RQ14]
      .fb_o          (fb[k])
    );
  end

endmodule

// file: bench/fab_array_assertions.sv
// concurrent checks on the ports of the fuse array top
`timescale 1ns/100ps
module fab_array_assertions #(
  parameter fab_pkg::fab_variant_t VARIANT     = fab_pkg::FAB_MD_REG4,
  parameter bit                    FAST_SERIES = 1'b1
) (
  input wire logic                        clock_i,
  input wire logic                        rst_n_i,
  input wire logic [fab_pkg::NUM_OUT-1:0] io_o,
  input wire logic [fab_pkg::NUM_OUT-1:0] io_oe_o,
  input wire logic                        out_en_n_i,
  input wire logic                        preload_en_i,
  input wire logic [fab_pkg::NUM_OUT-1:0] preload_data_i,
  input wire logic                        prog_blow_i,
  input wire logic                        verify_req_i,
  input wire logic                        verify_valid_o,
  input wire logic                        secure_blow_i,
  input wire logic                        secured_o,
  input wire logic                        refused_o
);
  import fab_pkg::*;
  // registered cells of this variant; medium pins are active low
  localparam logic [7:0] REGM = (VARIANT == FAB_MD_REG4) ? 8'h3C :
                                (VARIANT == FAB_MD_REG6) ? 8'h7E :
                                (VARIANT == FAB_MD_REG8) ? 8'hFF : 8'h00;
  localparam bit         MED  = (VARIANT >= FAB_MD_COMB);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  property p_verify_answer;
    verify_req_i && !prog_blow_i && !secured_o |=> verify_valid_o;
  endproperty
  a_verify_answer: assert property (p_verify_answer)
    else $error("verify request not answered");
  property p_secure_hold;
    secure_blow_i || secured_o |=> secured_o;
  endproperty
  a_secure_hold: assert property (p_secure_hold)
    else $error("security state lost");
  property p_refuse;
    (prog_blow_i || verify_req_i) && secured_o |=> refused_o && !verify_valid_o;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("request accepted while secured");
  property p_refuse_cause;
    refused_o |-> $past(secured_o) && ($past(prog_blow_i) || $past(verify_req_i));
  endproperty
  a_refuse_cause: assert property (p_refuse_cause)
    else $error("refusal without cause");
  property p_reg_enable;
    (io_oe_o & REGM) == (out_en_n_i ? 8'h00 : REGM);
  endproperty
  a_reg_enable: assert property (p_reg_enable)
    else $error("registered pin enable wrong");
  property p_preload;
    MED && FAST_SERIES && preload_en_i |=> (io_o & REGM) == (~$past(preload_data_i) & REGM);
  endproperty
  a_preload: assert property (p_preload)
    else $error("preload value not loaded");
  property p_reset_regs;
    disable iff (1'b0) !rst_n_i |-> (io_o & REGM) == REGM && !secured_o && !refused_o;
  endproperty
  a_reset_regs: assert property (p_reset_regs)
    else $error("registers not cleared in reset");
  property p_reset_terms;
    disable iff (1'b0) !rst_n_i && MED |-> (io_oe_o & ~REGM) == 8'h00;
  endproperty
  a_reset_terms: assert property (p_reset_terms)
    else $error("output enable term true with intact fuses");
endmodule

// file: bench/fab_board.sv
// board model resolving the shared pins seen by the array
`timescale 1ns/100ps
module fab_board (
  input  wire logic [fab_pkg::NUM_OUT-1:0] io_o_i,
  input  wire logic [fab_pkg::NUM_OUT-1:0] io_oe_i,
  input  wire logic [fab_pkg::NUM_OUT-1:0] ext_i,
  output logic      [fab_pkg::NUM_OUT-1:0] io_i_o
);
  import fab_pkg::*;
  // a driven pin reads back itself, a floating one the board pattern
  assign io_i_o = (io_oe_i & io_o_i) | (~io_oe_i & ext_i);
endmodule

// file: bench/fab_array_top_tb.sv
// self-checking bench of the fuse array top
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module fab_array_top_tb;
  import fab_pkg::*;
  logic       clock_i = 0, rst_n_i = 0, oen_n = 0, pl_en = 0, blow = 0, vreq = 0, sblow = 0;
  logic [9:0] in_v    = 0;
  logic [7:0] ext     = 0, pl_d = 0, io_o, io_oe, io_i;
  logic [10:0] addr   = 0;
  logic       vv, vd, sec, ref_p, exp_v;
  int         bad_count = 0, num_checks = 0, seed = 31;
  logic       q[$];
  always #4 clock_i = ~clock_i;
  fab_array_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .in_i(in_v), .io_i(io_i),
    .io_o(io_o), .io_oe_o(io_oe), .out_en_n_i(oen_n), .preload_en_i(pl_en),
    .preload_data_i(pl_d), .prog_blow_i(blow), .prog_addr_i(addr), .verify_req_i(vreq),
    .verify_valid_o(vv), .verify_data_o(vd), .secure_blow_i(sblow), .secured_o(sec),
    .refused_o(ref_p));
  fab_board brd (.io_o_i(io_o), .io_oe_i(io_oe), .ext_i(ext), .io_i_o(io_i));
  ////////////////////////////////////////////////////////////////////////
  // inputs always change 1 ns after the edge
  task tick;
    @(posedge clock_i);
    #1;
  endtask
  // blow a whole row except up to two kept lines, back to back
  task blow_row(input int row, input int k0, input int k1);
    for (int l = 0; l < 32; l++) begin
      addr = 11'(row * 32 + l);
      blow = (l != k0 && l != k1);
      tick;
    end
  endtask
  // read one fuse, noting the answer the monitor must see
  task verify(input int a, input logic e);
    addr = 11'(a);
    vreq = 1;
    if (sec !== 1'b1) q.push_back(e);
    tick;
    vreq = 0;
    tick;
  endtask
  // verify answers are matched against the oldest note
  always @(posedge clock_i) begin
    if (vv === 1'b1) begin
      if (q.size() == 0) `CHK("verify_valid_o", 1'b0, vv)
      else begin
        exp_v = q.pop_front();
        `CHK("verify_data_o", exp_v, vd)
      end
    end
  end
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    #20000;
    bad_count++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock_i);
    #1 rst_n_i = 1;
    `CHK("reg pins", 4'hF, io_o[5:2])
    `CHK("pin enables", 8'h3C, io_oe)
    $display("test reset done");
    verify(16 * 32, 1'b0);
    blow_row(16, 0, 99);
    blow_row(17, 2, 3);
    blow_row(24, 99, 99);
    blow_row(0, 99, 99);
    blow_row(1, 3, 99);
    blow = 0;
    verify(16 * 32 + 1, 1'b1);
    verify(16 * 32, 1'b0);
    verify(17 * 32 + 2, 1'b0);
    $display("test program done");
    repeat (20) begin
      in_v = 10'($random(seed));
      ext  = 8'($random(seed));
      tick;
      `CHK("reg pin2", ~in_v[0], io_o[2])
      `CHK("reg pin3", 1'b0, io_o[3])
      `CHK("idle pins", 2'b11, io_o[5:4])
      `CHK("comb pin0", in_v[1], io_o[0])
      `CHK("comb enables", 2'b01, io_oe[1:0])
    end
    pl_d  = 8'($random(seed));
    pl_en = 1;
    tick;
    pl_en = 0;
    `CHK("preload", ~pl_d[5:2], io_o[5:2])
    oen_n = 1;
    tick;
    `CHK("enables off", 8'h01, io_oe)
    oen_n = 0;
    $display("test logic done");
    sblow = 1;
    tick;
    sblow = 0;
    `CHK("secured", 1'b1, sec)
    blow_row(8, 99, 99);
    blow = 0;
    `CHK("refused", 1'b1, ref_p)
    `CHK("row8 untouched", 1'b0, io_oe[1])
    verify(16 * 32 + 1, 1'b1);
    `CHK("verify notes left", 0, q.size())
    $display("test security done");
    results;
  end
endmodule
bind fab_array_top fab_array_assertions #(.VARIANT(VARIANT), .FAST_SERIES(FAST_SERIES)) chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .io_o(io_o), .io_oe_o(io_oe_o),
  .out_en_n_i(out_en_n_i), .preload_en_i(preload_en_i), .preload_data_i(preload_data_i),
  .prog_blow_i(prog_blow_i), .verify_req_i(verify_req_i), .verify_valid_o(verify_valid_o),
  .secure_blow_i(secure_blow_i), .secured_o(secured_o), .refused_o(refused_o));
